// *** logic/conv_pkg.sv ***
// constants shared by the data converter controller and its sub-blocks
// assumes a 100 MHz system clock and a word-aligned classic wishbone bus
package conv_pkg;
  // converter data widths
  localparam int unsigned RES_W  = 10;
  localparam int unsigned PAIR_W = 16;
  localparam int unsigned PAD_W  = 6;

  // conversion timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CONV_TIME_NS  = 6500;
  localparam int unsigned CONV_CYCLES   = 13;
  localparam int unsigned TICK_SYS_CYC  = CONV_TIME_NS / CONV_CYCLES / CLK_PERIOD_NS;
  localparam logic [6:0]  PRESCALE_RST  = 7'(TICK_SYS_CYC - 1);

  // steps of one conversion, counted in converter clocks
  localparam logic [3:0] STEP_FIRST  = 4'h1;
  localparam logic [3:0] STEP_SAMPLE = 4'h3;
  localparam logic [3:0] STEP_LAST   = 4'(CONV_CYCLES);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_INSEL    = 8'h04;
  localparam logic [7:0] OFS_RES_LO   = 8'h08;
  localparam logic [7:0] OFS_RES_HI   = 8'h0C;
  localparam logic [7:0] OFS_PRESCALE = 8'h10;

  // converter_control_reg fields
  localparam int unsigned CTL_ENABLE = 0;
  localparam int unsigned CTL_DAC    = 1;
  localparam int unsigned CTL_LEFT_ALIGN_SELECT   = 2;
  localparam int unsigned CTL_GO     = 3;
  localparam int unsigned CTL_DONE   = 4;
  localparam int unsigned CTL_REF    = 5;
  localparam int unsigned CTL_TRIG   = 6;

  // input select fields
  localparam int unsigned INS_CHAN    = 0;
  localparam int unsigned INS_DIFF    = 3;
  localparam int unsigned INS_CONNECT = 4;
  localparam int unsigned INS_TEMP    = 5;

  // reset values and special codes
  localparam logic [7:0]        CTRL_RST     = 8'h00;
  localparam logic [7:0]        INSEL_RST    = 8'h00;
  localparam logic [PAIR_W-1:0] PAIR_RST     = 16'h0000;
  localparam logic [2:0]        INT_PAIR     = 3'h3;
  localparam logic [RES_W-1:0]  CODE_MID     = 10'h200;
  localparam logic [RES_W-1:0]  CODE_MIN_NEG = 10'h201;

  // sequencer states, gray along idle -> run
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } sar_state_t;
endpackage

// *** logic/conv_tick_gen.sv ***
// converter clock prescaler: one-cycle tick every (div+1) system clocks
// assumes restart is pulsed when a conversion starts
`timescale 1ns/1ps
`default_nettype none
module conv_tick_gen #(
  parameter int unsigned DIV_W = 7
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_run,
  input  wire logic             i_restart,
  input  wire logic [DIV_W-1:0] i_div,
  output logic                  o_tick
);
  logic [DIV_W-1:0] cnt_q;
  wire              wrap = (cnt_q == i_div);

  // restart aligns the first converter clock to the start
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (!i_run || i_restart) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
      o_tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// *** logic/sar_core.sv ***
// successive-approximation sequencer shared by adc and dac directions
// assumes i_cmp is high when the held input is at or above the trial level
`timescale 1ns/1ps
`default_nettype none
module sar_core
  import conv_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_tick,
  input  wire logic             i_start,
  input  wire logic             i_abort,
  input  wire logic             i_dac_mode,
  input  wire logic [RES_W-1:0] i_dac_code,
  input  wire logic             i_cmp,
  output logic                  o_busy,
  output logic                  o_done,
  output logic                  o_sample,
  output logic                  o_dac_update,
  output logic [RES_W-1:0]      o_trial
);
  sar_state_t       state_q;
  logic [3:0]       step_q;
  logic             dac_q;
  logic [RES_W-1:0] trial_d;

  wire       last  = (step_q == STEP_LAST);
  wire [3:0] nstep = step_q + 4'h1;
  wire [3:0] idx   = STEP_LAST - step_q;
  wire       decide = (step_q > STEP_SAMPLE);

  // bit decision: drop the trial bit if below, then try the next one
  always_comb begin
    trial_d = o_trial;
    if (!dac_q && decide) begin
      if (!i_cmp) trial_d[idx] = 1'b0;
      if (idx != 4'h0) trial_d[idx - 4'h1] = 1'b1;
    end
  end

  // sequencer: start, 13 converter clocks, done pulse
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q      <= ST_IDLE;
      step_q       <= STEP_FIRST;
      dac_q        <= 1'b0;
      o_trial      <= CODE_MID;
      o_done       <= 1'b0;
      o_sample     <= 1'b0;
      o_dac_update <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          o_sample     <= 1'b0;
          o_dac_update <= 1'b0;
          if (i_start) begin
            state_q <= ST_RUN;
            step_q  <= STEP_FIRST;
            dac_q   <= i_dac_mode;
            // dac value is buffered once, held for the whole conversion
            o_trial <= i_dac_mode ? i_dac_code : CODE_MID;
          end
        end
        ST_RUN: begin
          if (i_abort) begin
            state_q      <= ST_IDLE;
            o_sample     <= 1'b0;
            o_dac_update <= 1'b0;
          end else if (i_tick) begin
            o_trial <= trial_d;
            if (last) begin
              state_q      <= ST_IDLE;
              o_done       <= 1'b1;
              o_dac_update <= 1'b0;
            end else begin
              step_q       <= nstep;
              o_sample     <= !dac_q && (nstep == STEP_SAMPLE);
              o_dac_update <= dac_q && (nstep == STEP_LAST);
            end
          end
        end
      endcase
    end
  end

  assign o_busy = (state_q == ST_RUN);
endmodule
`default_nettype wire

// *** logic/dual_mode_data_converter_ctrl.sv ***
// control and result formatting for a 10-bit dual-mode data converter
// assumes a classic wishbone master and an analog front end with a comparator
//
// Operation
// - one mode at a time, shared SAR core
// - eight-way mux: single-ended or differential
// - results are signed two's complement
// - result placed right or left in pair
// - right aligned: sign fills upper six bits
// - left aligned: lowest six bits zero
// - pair readable in adc, writable in dac
// - zero, full and half positive codes
// - full and half negative codes
// - reference internal or half supply
// - nominal 6.5 us per conversion
// - start by software or timer
// - interrupt request on each completion
// - internal temperature and supply selections
// - dac runs core in reverse
// - thirteen converter clocks per conversion
// - go bit starts, stays, hardware clears
// - completion sets flag, writes result
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dual_mode_data_converter_ctrl
  import conv_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // classic wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADDR_W-1:0] i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic      [31:0]       o_wb_dat,
  output logic                   o_wb_ack,
  // trigger and analog side
  input  wire logic              i_timer_ovf,
  input  wire logic              i_cmp,
  output logic                   o_irq,
  output logic                   o_enable,
  output logic                   o_dac_mode,
  output logic [2:0]             o_mux_chan,
  output logic                   o_mux_diff,
  output logic                   o_mux_connect,
  output logic                   o_mux_internal,
  output logic                   o_internal_temp,
  output logic                   o_ref_half_supply,
  output logic                   o_sample,
  output logic                   o_dac_update,
  output logic [RES_W-1:0]       o_trial
);
  import conv_pkg::*;

  // full-address match; offsets are word aligned, so byte lanes 1..3 never hit
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    logic [ADDR_W-1:0] ofs_w;
    ofs_w = ADDR_W'(ofs);
    hit   = (a == ofs_w);
  endfunction

  // right or left placement of a signed result in the pair
  function automatic logic [PAIR_W-1:0] place(input logic [RES_W-1:0] r,
                                              input logic             left);
    place = left ? {r, {PAD_W{1'b0}}}
                 : {{PAD_W{r[RES_W-1]}}, r};
  endfunction

  // control state
  logic              enable_q;
  logic              dac_q;
  logic              left_align_select_q;
  logic              busy_q;
  logic              done_q;
  logic              ref_q;
  logic              trig_q;
  logic [2:0]        chan_q;
  logic              diff_q;
  logic              connect_q;
  logic              temp_q;
  logic [6:0]        prescale_q;
  logic [PAIR_W-1:0] pair_q;

  // core and prescaler wiring
  logic              tick;
  logic              core_busy;
  logic              core_done;
  logic [RES_W-1:0]  core_trial;
  logic              core_sample;
  logic              core_update;

  // register selects, shared by the write strobes and the read mux
  wire sel_ctrl = hit(i_wb_adr, OFS_CTRL);
  wire sel_ins  = hit(i_wb_adr, OFS_INSEL);
  wire sel_lo   = hit(i_wb_adr, OFS_RES_LO);
  wire sel_hi   = hit(i_wb_adr, OFS_RES_HI);
  wire sel_pre  = hit(i_wb_adr, OFS_PRESCALE);

  // bus decode
  wire       bus_req = i_wb_cyc & i_wb_stb;
  wire       wr_take = bus_req & i_wb_we & o_wb_ack & i_wb_sel[0];
  wire [7:0] wd      = i_wb_dat[7:0];
  wire       wr_ctrl = wr_take & sel_ctrl;
  wire       wr_ins  = wr_take & sel_ins;
  wire       wr_lo   = wr_take & sel_lo;
  wire       wr_hi   = wr_take & sel_hi;
  wire       wr_pre  = wr_take & sel_pre;

  // start sources; a start needs the enable set, no second start while busy
  wire sw_go  = wr_ctrl & wd[CTL_GO] & wd[CTL_ENABLE];
  wire tmr_go = enable_q & trig_q & i_timer_ovf;
  wire start  = (sw_go | tmr_go) & ~busy_q;
  // clearing the enable abandons a running conversion
  wire abort  = wr_ctrl & ~wd[CTL_ENABLE];

  // offset-binary core code to signed, with the -512 code folded to -511
  wire [RES_W-1:0] signed_raw = {~core_trial[RES_W-1], core_trial[RES_W-2:0]};
  wire [RES_W-1:0] adc_code   = (signed_raw == CODE_MID) ? CODE_MIN_NEG
                                                         : signed_raw;

  // dac value taken from the pair in the current alignment
  wire [RES_W-1:0] dac_code = left_align_select_q ? pair_q[PAIR_W-1:PAD_W]
                                     : pair_q[RES_W-1:0];

  // the pair reads as zero while it is the dac's write-only input
  wire [PAIR_W-1:0] pair_rd = dac_q ? PAIR_RST : pair_q;

  // readback of the control byte shows live busy and done state
  wire [7:0] ctrl_rd = 8'({trig_q, ref_q, done_q, busy_q, left_align_select_q, dac_q, enable_q});
  wire [7:0] ins_rd  = 8'({temp_q, connect_q, diff_q, chan_q});

  // read mux, unmapped words read zero
  wire [7:0] rd_byte =
    sel_ctrl ? ctrl_rd :
    sel_ins  ? ins_rd :
    sel_lo   ? pair_rd[7:0] :
    sel_hi   ? pair_rd[15:8] :
    sel_pre  ? {1'b0, prescale_q} : 8'h00;

  // internal channel is differential pair three
  wire internal_sel = diff_q & (chan_q == INT_PAIR);
  wire ref_half     = ref_q & ~internal_sel;

  // one ack per request, dropped the cycle after
  // a master that keeps stb up gets another ack every second cycle, without dropping stb
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req & ~o_wb_ack;
      if (bus_req & ~o_wb_ack) begin
        o_wb_dat <= {24'h00_0000, rd_byte};
      end
    end
  end

  // control register; mode bit switches the shared core direction
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_q <= CTRL_RST[CTL_ENABLE];
      dac_q    <= CTRL_RST[CTL_DAC];
      left_align_select_q   <= CTRL_RST[CTL_LEFT_ALIGN_SELECT];
      ref_q    <= CTRL_RST[CTL_REF];
      trig_q   <= CTRL_RST[CTL_TRIG];
    end else if (wr_ctrl) begin
      enable_q <= wd[CTL_ENABLE];
      dac_q    <= wd[CTL_DAC];
      left_align_select_q   <= wd[CTL_LEFT_ALIGN_SELECT];
      ref_q    <= wd[CTL_REF];
      trig_q   <= wd[CTL_TRIG];
    end
  end

  // busy follows the core; software clears it only by writing the enable bit low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= CTRL_RST[CTL_GO];
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (core_done | abort) begin
      busy_q <= 1'b0;
    end
  end

  // completion flag: write one clears, a new completion wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= CTRL_RST[CTL_DONE];
    end else if (core_done) begin
      done_q <= 1'b1;
    end else if (wr_ctrl & wd[CTL_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // input select and prescaler
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chan_q     <= INSEL_RST[INS_CHAN +: 3];
      diff_q     <= INSEL_RST[INS_DIFF];
      connect_q  <= INSEL_RST[INS_CONNECT];
      temp_q     <= INSEL_RST[INS_TEMP];
      prescale_q <= PRESCALE_RST;
    end else begin
      if (wr_ins) begin
        chan_q    <= wd[INS_CHAN +: 3];
        diff_q    <= wd[INS_DIFF];
        connect_q <= wd[INS_CONNECT];
        temp_q    <= wd[INS_TEMP];
      end
      if (wr_pre) begin
        prescale_q <= wd[6:0];
      end
    end
  end

  // result pair: written by the core in adc, by software in dac
  // each byte lands at once; no latching between the halves
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pair_q <= PAIR_RST;
    end else if (core_done & ~dac_q) begin
      pair_q <= place(adc_code, left_align_select_q);
    end else if (dac_q) begin
      // writes in adc mode fall through untouched
      if (wr_lo) pair_q[7:0]  <= wd;
      if (wr_hi) pair_q[15:8] <= wd;
    end
  end

  // analog-side controls, registered so the pins never glitch
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq             <= 1'b0;
      o_enable          <= 1'b0;
      o_dac_mode        <= 1'b0;
      o_mux_chan        <= 3'h0;
      o_mux_diff        <= 1'b0;
      o_mux_connect     <= 1'b0;
      o_mux_internal    <= 1'b0;
      o_internal_temp   <= 1'b0;
      o_ref_half_supply <= 1'b0;
    end else begin
      o_irq             <= done_q;
      o_enable          <= enable_q;
      o_dac_mode        <= dac_q;
      o_mux_chan        <= chan_q;
      o_mux_diff        <= diff_q;
      o_mux_connect     <= connect_q;
      o_mux_internal    <= internal_sel;
      o_internal_temp   <= temp_q;
      // internal channels always use the fixed reference
      o_ref_half_supply <= ref_half;
    end
  end

  // converter clock from the system clock
  // restarting at each start keeps every conversion the same length
  conv_tick_gen #(
    .DIV_W (7)
  ) u_tick (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_run     (busy_q),
    .i_restart (start),
    .i_div     (prescale_q),
    .o_tick    (tick)
  );

  // 13-step sequencer, sample in step three, dac update in step 13
  sar_core u_core (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_tick       (tick),
    .i_start      (start),
    .i_abort      (abort),
    .i_dac_mode   (dac_q),
    .i_dac_code   (dac_code),
    .i_cmp        (i_cmp),
    .o_busy       (core_busy),
    .o_done       (core_done),
    .o_sample     (core_sample),
    .o_dac_update (core_update),
    .o_trial      (core_trial)
  );

  assign o_sample     = core_sample;
  assign o_dac_update = core_update;
  assign o_trial      = core_trial;

  // core_busy matches busy_q except at completion, where it drops one cycle before busy_q; kept as the core's own view of the run
  wire unused_busy = core_busy;
endmodule
`default_nettype wire

// *** sim/conv_ctrl_chk.sv ***
// port checker for the dual-mode data converter controller
// assumes one clock domain, async active-high reset, bound to the top
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_chk
  import conv_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_wb_cyc,
  input wire logic              i_wb_stb,
  input wire logic              i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0]        i_wb_sel,
  input wire logic [31:0]       i_wb_dat,
  input wire logic [31:0]       o_wb_dat,
  input wire logic              o_wb_ack,
  input wire logic              o_irq,
  input wire logic              o_enable,
  input wire logic              o_dac_mode,
  input wire logic [2:0]        o_mux_chan,
  input wire logic              o_mux_diff,
  input wire logic              o_mux_internal,
  input wire logic              o_ref_half_supply,
  input wire logic              o_sample,
  input wire logic              o_dac_update
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // a flag clear must come from a committed write-one to the done bit
  wire clr_wr = o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_dat[CTL_DONE]
    && (i_wb_adr == ADDR_W'(OFS_CTRL));

  a_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_rd_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_sample_adc_only: assert property (o_sample |-> o_enable && !o_dac_mode)
    else $error("sample pulse outside adc mode");
  a_update_dac_only: assert property (o_dac_update |-> o_enable && o_dac_mode)
    else $error("output update outside dac mode");
  a_irq_clear_cause: assert property ($fell(o_irq) |-> $past(clr_wr, 2))
    else $error("irq dropped without a flag clear");
  a_irq_needs_enable: assert property ($rose(o_irq) |-> $past(o_enable, 2))
    else $error("completion while converter disabled");
  a_mux_internal_sel: assert property (o_mux_internal == (o_mux_diff && o_mux_chan == 3'h3))
    else $error("internal channel decode wrong");
  a_ref_internal_use: assert property (o_ref_half_supply |-> !o_mux_internal)
    else $error("half supply reference on internal channel");
endmodule

bind dual_mode_data_converter_ctrl conv_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
  .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_dat, .o_wb_ack, .o_irq, .o_enable, .o_dac_mode, .o_mux_chan, .o_mux_diff,
  .o_mux_internal, .o_ref_half_supply, .o_sample, .o_dac_update
);
`default_nettype wire

// *** sim/analog_src_model.sv ***
// analog front end: sample-and-hold plus comparator against the trial code
// assumes a signed input level relative to mid supply, in converter lsbs
`timescale 1ns/1ps
`default_nettype none
module analog_src_model
  import conv_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_sample,
  input  wire logic signed [10:0] i_level,
  input  wire logic [RES_W-1:0]   i_trial,
  output logic                    o_cmp
);
  logic [10:0] held_q;
  // level tracked while sampling and frozen after it, later input changes do not leak in
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) held_q <= 11'h000;
    else if (i_sample) held_q <= 11'(i_level + 11'sd512);
  end
  // offset-binary compare, high at or above the trial level
  assign o_cmp = (held_q >= {1'b0, i_trial});
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the dual-mode data converter controller
// assumes the analog source model on the comparator and a wishbone master here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import conv_pkg::*;
  logic i_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_timer_ovf, i_cmp;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rdat;
  logic o_wb_ack, o_irq, o_enable, o_dac_mode, o_mux_diff, o_mux_connect;
  logic o_mux_internal, o_internal_temp, o_ref_half_supply, o_sample, o_dac_update;
  logic [2:0] o_mux_chan;
  logic [RES_W-1:0] o_trial, v;
  logic signed [10:0] level;
  int failures, n_compared, cycles, wait_n;

  dual_mode_data_converter_ctrl uut (
    .i_clk (i_clk), .i_rst (i_rst), .i_wb_cyc (i_wb_cyc), .i_wb_stb (i_wb_stb),
    .i_wb_we (i_wb_we), .i_wb_adr (i_wb_adr), .i_wb_sel (i_wb_sel), .i_wb_dat (i_wb_dat),
    .o_wb_dat (o_wb_dat), .o_wb_ack (o_wb_ack), .i_timer_ovf (i_timer_ovf), .i_cmp (i_cmp),
    .o_irq (o_irq), .o_enable (o_enable), .o_dac_mode (o_dac_mode), .o_mux_chan (o_mux_chan),
    .o_mux_diff (o_mux_diff), .o_mux_connect (o_mux_connect),
    .o_mux_internal (o_mux_internal), .o_internal_temp (o_internal_temp),
    .o_ref_half_supply (o_ref_half_supply), .o_sample (o_sample),
    .o_dac_update (o_dac_update), .o_trial (o_trial)
  );
  analog_src_model u_src (.i_clk, .i_rst, .i_sample(o_sample), .i_level(level),
    .i_trial(o_trial), .o_cmp(i_cmp));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // hang guard, far above the about 1500 cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_wb_cyc <= 1'b1; i_wb_stb <= 1'b1; i_wb_we <= w; i_wb_adr <= a;
    i_wb_dat <= {24'h00_0000, d}; i_wb_sel <= 4'h1;
    // only the run timeout ends this wait
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'b1);
    rdat = o_wb_dat;
    i_wb_cyc <= 1'b0; i_wb_stb <= 1'b0; i_wb_we <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wait_irq();
    wait_n = 0;
    while (o_irq !== 1'b1 && wait_n < 2000) begin
      @(posedge i_clk);
      wait_n++;
    end
    chk(o_irq, 1);
  endtask
  task automatic rd_pair(output logic [15:0] p);
    wb(0, OFS_RES_LO, 8'h00);
    p[7:0] = rdat[7:0];
    wb(0, OFS_RES_HI, 8'h00);
    p[15:8] = rdat[7:0];
  endtask
  task automatic clear_flag();
    wb(1, OFS_CTRL, 8'h11);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 0);
  endtask

  task automatic t_reset();
    wb(0, OFS_CTRL, 8'h00);
    chk(rdat, 32'h0000_0000);
    chk(o_trial, CODE_MID);
    wb(0, OFS_PRESCALE, 8'h00);
    chk(rdat, 32'h0000_0031);
    wb(0, 8'h14, 8'h00);
    chk(rdat, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_adc();
    int lv[5] = '{0, 256, 511, -256, -511};
    logic [15:0] p, q;
    wb(1, OFS_PRESCALE, 8'h01);
    for (int i = 0; i < 10; i++) begin
      level = 11'(lv[i % 5]);
      v = level[9:0];
      wb(1, OFS_CTRL, (i >= 5) ? 8'h0D : 8'h09);
      wb(0, OFS_CTRL, 8'h00);
      chk(rdat[3], 1);
      wait_irq();
      wb(0, OFS_CTRL, 8'h00);
      chk(rdat[4:3], 2'b10);
      rd_pair(p);
      chk(p, (i >= 5) ? {v, 6'h00} : {{6{v[9]}}, v});
      if (i >= 5) chk(p[15:8], v[9:2]);
      wb(1, OFS_RES_LO, 8'h5A);
      rd_pair(q);
      chk(q, p);
      clear_flag();
    end
    $display("test adc done");
  endtask
  task automatic t_timing();
    level = 11'sd0;
    for (int k = 0; k < 2; k++) begin
      wb(1, OFS_PRESCALE, k ? 8'h31 : 8'h01);
      wb(1, OFS_CTRL, 8'h09);
      wait_irq();
      chk(wait_n >= (k ? 647 : 23) && wait_n <= (k ? 653 : 29), 1);
      clear_flag();
    end
    wb(1, OFS_PRESCALE, 8'h01);
    $display("test timing done");
  endtask
  task automatic t_timer();
    logic [15:0] p;
    level = 11'sd256;
    wb(1, OFS_CTRL, 8'h41);
    i_timer_ovf <= 1'b1;
    @(posedge i_clk);
    i_timer_ovf <= 1'b0;
    wait_irq();
    rd_pair(p);
    chk(p, 16'h0100);
    clear_flag();
    $display("test timer done");
  endtask
  task automatic t_dac();
    logic [15:0] pr;
    int n;
    for (int j = 0; j < 2; j++) begin
      pr = j ? 16'hA940 : 16'hFEA5;
      wb(1, OFS_CTRL, j ? 8'h07 : 8'h03);
      wb(1, OFS_RES_LO, pr[7:0]);
      wb(1, OFS_RES_HI, pr[15:8]);
      wb(0, OFS_RES_LO, 8'h00);
      chk(rdat, 32'h0000_0000);
      wb(1, OFS_CTRL, j ? 8'h0F : 8'h0B);
      n = 0;
      while (o_dac_update !== 1'b1 && n < 200) begin
        @(posedge i_clk);
        n++;
      end
      chk(o_dac_update, 1);
      chk({o_enable, o_dac_mode}, 2'b11);
      chk(o_trial, 10'h2A5);
      wait_irq();
      clear_flag();
    end
    $display("test dac done");
  endtask
  task automatic t_abort();
    wb(1, OFS_CTRL, 8'h09);
    wb(1, OFS_CTRL, 8'h00);
    wb(0, OFS_CTRL, 8'h00);
    chk(rdat, 32'h0000_0000);
    repeat (60) @(posedge i_clk);
    chk(o_irq, 0);
    $display("test abort done");
  endtask
  task automatic t_mux();
    logic [7:0] iv[3] = '{8'h15, 8'h2B, 8'h0B};
    logic in_q;
    wb(1, OFS_CTRL, 8'h21);
    foreach (iv[m]) begin
      wb(1, OFS_INSEL, iv[m]);
      // pin copies are registered once more after the select register
      @(posedge i_clk);
      in_q = iv[m][3] && iv[m][2:0] == 3'h3;
      chk({o_mux_chan, o_mux_diff, o_mux_connect, o_mux_internal, o_internal_temp,
        o_ref_half_supply}, {iv[m][2:0], iv[m][3], iv[m][4], in_q, iv[m][5], !in_q});
    end
    $display("test mux done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    i_rst = 1'b1; i_wb_cyc = 1'b0; i_wb_stb = 1'b0; i_wb_we = 1'b0; i_wb_adr = 8'h00;
    i_wb_sel = 4'h0; i_wb_dat = 32'h0000_0000; i_timer_ovf = 1'b0; level = 11'sd0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_adc();
    t_timing();
    t_timer();
    t_dac();
    t_abort();
    t_mux();
    final_report();
  end
endmodule
`default_nettype wire
